//--- pcp_assertions.sv
// Concurrent checks on the pump control block ports
`timescale 1ns/1ns

module pcp_assertions
   import pcp_pkg::*;
#(
   parameter int PWRUP_RST_CYC = 5,
   parameter int DIV_W = 5
) (
   // Clock and reset
   input logic clk,
   input logic nrst,
   // Comparison events
   input logic main_compare_strobe,
   input logic aux_compare_strobe,
   // Loop controls
   input logic main_counters_held,
   input logic aux_counters_held,
   input logic main_pump_hiz,
   input logic aux_pump_hiz,
   // Event strobes, main ones divided, aux lock detect at full rate
   input logic main_pd_sample_strobe,
   input logic main_lock_detect_strobe,
   input logic aux_lock_detect_strobe,
   // Fields and status
   input pcp_slip_t cycle_slip_reduction,
   input logic lock_detect_quarter_rate,
   input logic word_accepted,
   input logic power_up_reset_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   ////////////////////////////////////////////////////////////////////////////////
   property p_main_hold; main_counters_held |-> main_pump_hiz; endproperty
   a_main_hold: assert property (p_main_hold) else $error("main held, pump driven");
   property p_aux_hold; aux_counters_held |-> aux_pump_hiz; endproperty
   a_aux_hold: assert property (p_aux_hold) else $error("aux held, pump driven");
   // One cycle of grace while the power state settles
   property p_pwrup;
      power_up_reset_active[*2] |-> main_counters_held && aux_counters_held;
   endproperty
   a_pwrup: assert property (p_pwrup) else $error("power-up reset not holding");
   property p_aux_full;
      aux_compare_strobe && !aux_counters_held ##1 !aux_counters_held |-> aux_lock_detect_strobe;
   endproperty
   a_aux_full: assert property (p_aux_full) else $error("aux lock strobe divided");
   property p_main_full;
      main_compare_strobe && !lock_detect_quarter_rate && !main_counters_held
         ##1 !main_counters_held |-> main_lock_detect_strobe;
   endproperty
   a_main_full: assert property (p_main_full) else $error("main lock strobe lost");
   property p_slip_off;
      main_compare_strobe && cycle_slip_reduction == 2'h0 && !main_counters_held
         ##1 !main_counters_held |-> main_pd_sample_strobe;
   endproperty
   a_slip_off: assert property (p_slip_off) else $error("sample strobe divided at code 0");
   property p_held_quiet;
      main_counters_held[*2] |-> !main_pd_sample_strobe && !main_lock_detect_strobe;
   endproperty
   a_held_quiet: assert property (p_held_quiet) else $error("strobe while held");
   property p_fields;
      !word_accepted |-> $stable(cycle_slip_reduction) && $stable(lock_detect_quarter_rate);
   endproperty
   a_fields: assert property (p_fields) else $error("field moved without word");
   property p_cause;
      main_lock_detect_strobe || aux_lock_detect_strobe
         |-> $past(main_compare_strobe) || $past(aux_compare_strobe);
   endproperty
   a_cause: assert property (p_cause) else $error("strobe without event");

   ////////////////////////////////////////////////////////////////////////////////
   c_word: cover property (word_accepted);
   c_float: cover property (main_pump_hiz && !main_counters_held);
   c_slip3: cover property (cycle_slip_reduction == 2'h3 && main_pd_sample_strobe);
endmodule : pcp_assertions

//--- pcp_cfg.svh
// Offsets, field positions, reset values and timing counts for the pump control block
`ifndef PCP_CFG_SVH
`define PCP_CFG_SVH

// Serial word layout
`define PCP_WORD_W 24
`define PCP_SEL_MSB 3
`define PCP_SEL_LSB 0
`define PCP_SEL_TEST 4'hf
`define PCP_SEL_FAST 4'hd

// Test control word fields
`define PCP_AUX_FLOAT_BIT 4
`define PCP_MAIN_FLOAT_BIT 5
`define PCP_AUX_RST_BIT 6
`define PCP_MAIN_RST_BIT 7
`define PCP_QRATE_BIT 8

// Fastlock word fields
`define PCP_TOC_LSB 4
`define PCP_TOC_MSB 17
`define PCP_CPF_LSB 18
`define PCP_CPF_MSB 21
`define PCP_SLIP_LSB 22
`define PCP_SLIP_MSB 23

// Reset values
`define PCP_WORD_RESET 24'h00_0000
`define PCP_BIT_RESET 1'h0

// Divider ratios as log2 of the divide factor
`define PCP_QRATE_SHIFT 3'h2
`define PCP_SLIP0_SHIFT 3'h0
`define PCP_SLIP1_SHIFT 3'h1
`define PCP_SLIP2_SHIFT 3'h2
`define PCP_SLIP3_SHIFT 3'h4

// Timing
`define PCP_CLK_NS 40
`define PCP_PWRUP_RST_NS 200
`define PCP_PWRUP_RST_CYC ((`PCP_PWRUP_RST_NS + `PCP_CLK_NS - 1) / `PCP_CLK_NS)

`endif

//--- pcp_control.sv
// Control decode for the test control word and cycle slip setting of a dual synthesizer
`timescale 1ns/1ns
`include "pcp_cfg.svh"

module pcp_control
   import pcp_pkg::*;
#(
   parameter int PWRUP_RST_CYC = `PCP_PWRUP_RST_CYC,
   parameter int DIV_W = 5
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Serial link from host
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_latch,
   // Power control
   input wire logic chip_enable,
   input wire logic soft_power_down,
   // Phase detector comparison events
   input wire logic main_compare_strobe,
   input wire logic aux_compare_strobe,
   // Loop controls
   output logic main_counters_held,
   output logic aux_counters_held,
   output logic main_pump_hiz,
   output logic aux_pump_hiz,
   // Event strobes, main ones divided, aux lock detect at full rate
   output logic main_pd_sample_strobe,
   output logic main_lock_detect_strobe,
   output logic aux_lock_detect_strobe,
   // Decoded fields
   output pcp_slip_t cycle_slip_reduction,
   output logic [13:0] fastlock_timeout_count,
   output logic [3:0] fastlock_pump_current,
   output logic lock_detect_quarter_rate,
   // Status
   output logic word_accepted,
   output logic power_up_reset_active
);

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic pcp_shift_t slip_shift_of(input pcp_slip_t code);
      pcp_shift_t s;
      s = `PCP_SLIP0_SHIFT;
      case (code)
         2'h1: s = `PCP_SLIP1_SHIFT;
         2'h2: s = `PCP_SLIP2_SHIFT;
         2'h3: s = `PCP_SLIP3_SHIFT;
         default: s = `PCP_SLIP0_SHIFT;
      endcase
      return s;
   endfunction : slip_shift_of

   function automatic logic word_selects(input pcp_word_t w, input logic [3:0] sel);
      return w[`PCP_SEL_MSB:`PCP_SEL_LSB] == sel;
   endfunction : word_selects

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain

   pcp_word_t link_word;
   logic link_complete;
   logic take_word;

   pcp_serial_rx u_rx (
      .ser_clk(ser_clk),
      .nrst(nrst),
      .ser_data(ser_data),
      .ser_latch(ser_latch),
      .count_clear(take_word),
      .shift_word(link_word),
      .word_complete(link_complete)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Crossing: the latch level is synchronised, the word is quasi-static
   // because the shifter ignores clocks while the latch is high.

   logic latch_meta;
   logic latch_sync;
   logic latch_prev;
   logic latch_rise;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latch_meta <= 1'b0;
         latch_sync <= 1'b0;
         latch_prev <= 1'b0;
      end else begin
         latch_meta <= ser_latch;
         latch_sync <= latch_meta;
         latch_prev <= latch_sync;
      end
   end

   assign latch_rise = latch_sync && !latch_prev;

   // Sample the word one edge later so it has settled across the boundary
   pcp_word_t core_word;
   logic core_complete;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         take_word <= 1'b0;
      end else begin
         take_word <= latch_rise;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_word <= `PCP_WORD_RESET;
         core_complete <= 1'b0;
      end else if (latch_rise) begin
         core_word <= link_word;
         core_complete <= link_complete;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Word routing

   logic hit_test;
   logic hit_fast;

   assign hit_test = take_word && core_complete && word_selects(core_word, `PCP_SEL_TEST);
   assign hit_fast = take_word && core_complete && word_selects(core_word, `PCP_SEL_FAST);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         word_accepted <= 1'b0;
      end else begin
         word_accepted <= hit_test || hit_fast;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Test control word

   logic main_counter_reset;
   logic aux_counter_reset;
   logic main_pump_float;
   logic aux_pump_float;

   // Unused data bits are expected as zero and are simply not stored
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         main_counter_reset <= `PCP_BIT_RESET;
         aux_counter_reset <= `PCP_BIT_RESET;
         main_pump_float <= `PCP_BIT_RESET;
         aux_pump_float <= `PCP_BIT_RESET;
         lock_detect_quarter_rate <= `PCP_BIT_RESET;
      end else if (hit_test) begin
         main_counter_reset <= core_word[`PCP_MAIN_RST_BIT];
         aux_counter_reset <= core_word[`PCP_AUX_RST_BIT];
         main_pump_float <= core_word[`PCP_MAIN_FLOAT_BIT];
         aux_pump_float <= core_word[`PCP_AUX_FLOAT_BIT];
         lock_detect_quarter_rate <= core_word[`PCP_QRATE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Fastlock word: slip setting travels with timeout and pump current

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cycle_slip_reduction <= 2'h0;
         fastlock_timeout_count <= 14'h0000;
         fastlock_pump_current <= 4'h0;
      end else if (hit_fast) begin
         cycle_slip_reduction <= core_word[`PCP_SLIP_MSB:`PCP_SLIP_LSB];
         fastlock_timeout_count <= core_word[`PCP_TOC_MSB:`PCP_TOC_LSB];
         fastlock_pump_current <= core_word[`PCP_CPF_MSB:`PCP_CPF_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power-up sequencing

   logic ce_meta;
   logic ce_sync;
   logic powered;
   pcp_power_t pwr_state;
   pcp_power_t next_pwr_state;
   logic [15:0] pwr_count;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ce_meta <= 1'b0;
         ce_sync <= 1'b0;
      end else begin
         ce_meta <= chip_enable;
         ce_sync <= ce_meta;
      end
   end

   assign powered = ce_sync && !soft_power_down;

   // Either wake-up path passes through the same automatic reset
   always_comb begin
      next_pwr_state = pwr_state;
      case (pwr_state)
         PCP_OFF: begin
            if (powered) begin
               next_pwr_state = PCP_AUTO_RESET;
            end
         end
         PCP_AUTO_RESET: begin
            if (!powered) begin
               next_pwr_state = PCP_OFF;
            end else if (pwr_count == 16'(PWRUP_RST_CYC - 1)) begin
               next_pwr_state = PCP_RUN;
            end
         end
         PCP_RUN: begin
            if (!powered) begin
               next_pwr_state = PCP_OFF;
            end
         end
         default: next_pwr_state = PCP_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwr_state <= PCP_OFF;
      end else begin
         pwr_state <= next_pwr_state;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwr_count <= 16'h0000;
      end else if (pwr_state == PCP_AUTO_RESET) begin
         pwr_count <= pwr_count + 16'h0001;
      end else begin
         pwr_count <= 16'h0000;
      end
   end

   logic auto_reset;

   // Counters also stay cleared while powered down
   assign auto_reset = (pwr_state != PCP_RUN);

   ////////////////////////////////////////////////////////////////////////////////
   // Loop controls

   logic next_main_held;
   logic next_aux_held;

   assign next_main_held = main_counter_reset || auto_reset;
   assign next_aux_held = aux_counter_reset || auto_reset;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         main_counters_held <= 1'b1;
         aux_counters_held <= 1'b1;
         power_up_reset_active <= 1'b1;
      end else begin
         main_counters_held <= next_main_held;
         aux_counters_held <= next_aux_held;
         power_up_reset_active <= auto_reset;
      end
   end

   // A float bit never touches the counters, only the pump
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         main_pump_hiz <= 1'b1;
         aux_pump_hiz <= 1'b1;
      end else begin
         main_pump_hiz <= next_main_held || main_pump_float;
         aux_pump_hiz <= next_aux_held || aux_pump_float;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event dividers

   pcp_shift_t slip_shift;
   pcp_shift_t lock_shift;

   assign slip_shift = slip_shift_of(cycle_slip_reduction);
   assign lock_shift = lock_detect_quarter_rate ? `PCP_QRATE_SHIFT : `PCP_SLIP0_SHIFT;

   pcp_rate_div #(
      .CW(DIV_W)
   ) u_slip_div (
      .clk(clk),
      .nrst(nrst),
      .hold(main_counters_held),
      .shift_sel(slip_shift),
      .event_in(main_compare_strobe),
      .event_out(main_pd_sample_strobe)
   );

   pcp_rate_div #(
      .CW(DIV_W)
   ) u_lock_div (
      .clk(clk),
      .nrst(nrst),
      .hold(main_counters_held),
      .shift_sel(lock_shift),
      .event_in(main_compare_strobe),
      .event_out(main_lock_detect_strobe)
   );

   // The aux loop lock detect sees its full comparison rate whenever the aux counters are not held
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aux_lock_detect_strobe <= 1'b0;
      end else begin
         aux_lock_detect_strobe <= aux_compare_strobe && !aux_counters_held;
      end
   end

endmodule : pcp_control

//--- pcp_host_model.sv
// Host model shifting serial words into the pump control block
`timescale 1ns/1ns

module pcp_host_model (
   // Serial link
   output logic ser_clk,
   output logic ser_data,
   output logic ser_latch
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_latch = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link clock runs only inside a frame; leading gap keeps the latch high long enough
   task automatic send(input logic [23:0] w, input int n);
      #300;
      ser_latch = 1'b0;
      #16;
      for (int b = n - 1; b >= 0; b--) begin
         ser_data = w[b];
         #16 ser_clk = 1'b1;
         #16 ser_clk = 1'b0;
      end
      // Released line must not keep the last bit
      ser_data = ~ser_data;
      #16 ser_latch = 1'b1;
   endtask : send
endmodule : pcp_host_model

//--- pcp_pkg.sv
// Types shared by the pump control block
package pcp_pkg;

   typedef logic [23:0] pcp_word_t;
   typedef logic [1:0] pcp_slip_t;
   typedef logic [2:0] pcp_shift_t;

   typedef enum logic [1:0] {
      PCP_OFF,
      PCP_AUTO_RESET,
      PCP_RUN
   } pcp_power_t;

endpackage : pcp_pkg

//--- pcp_rate_div.sv
// Event divider by a power of two
`timescale 1ns/1ns
`include "pcp_cfg.svh"

module pcp_rate_div
   import pcp_pkg::*;
#(
   parameter int CW = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic hold,
   input pcp_shift_t shift_sel,
   // Events
   input wire logic event_in,
   output logic event_out
);

   logic [CW-1:0] count;
   logic [CW-1:0] mask;

   assign mask = CW'((1 << shift_sel) - 1);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
      end else if (hold) begin
         count <= '0;
      end else if (event_in) begin
         count <= (count >= mask) ? '0 : count + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         event_out <= 1'b0;
      end else begin
         event_out <= !hold && event_in && (count >= mask);
      end
   end

endmodule : pcp_rate_div

//--- pcp_serial_rx.sv
// Serial word shifter running on the host's serial clock
`timescale 1ns/1ns
`include "pcp_cfg.svh"

module pcp_serial_rx
   import pcp_pkg::*;
(
   // Link
   input wire logic ser_clk,
   input wire logic nrst,
   input wire logic ser_data,
   input wire logic ser_latch,
   // From core, pulses while the latch is high and the link clock is idle
   input wire logic count_clear,
   // To core
   output pcp_word_t shift_word,
   output logic word_complete
);

   logic [4:0] bit_count;

   ////////////////////////////////////////////////////////////////////////////////
   // Clocks seen while the latch is high are ignored, so the word stays still
   // for the core to pick up after the latch rises.
   always_ff @(posedge ser_clk or negedge nrst) begin
      if (!nrst) begin
         shift_word <= `PCP_WORD_RESET;
      end else if (!ser_latch) begin
         shift_word <= {shift_word[`PCP_WORD_W-2:0], ser_data};
      end
   end

   // The link clock stops between frames, so the count is cleared from the core
   // once the word has been captured; otherwise it would stay saturated.
   always_ff @(posedge ser_clk or negedge nrst or posedge count_clear) begin
      if (!nrst) begin
         bit_count <= 5'h0;
      end else if (count_clear) begin
         bit_count <= 5'h0;
      end else if (ser_latch) begin
         bit_count <= 5'h0;
      end else if (bit_count != 5'(`PCP_WORD_W)) begin
         bit_count <= bit_count + 5'h1;
      end
   end

   // Longer words keep the last bits shifted, shorter ones are refused
   assign word_complete = (bit_count == 5'(`PCP_WORD_W));

endmodule : pcp_serial_rx

//--- testbench.sv
// Self-checking bench for the pump control block
`timescale 1ns/1ns

module testbench;
   import pcp_pkg::*;
   localparam int PWR = 3;
   localparam logic [23:0] TW [6] = '{24'h00_001f, 24'h00_002f, 24'h00_004f,
      24'h00_008f, 24'h00_010f, 24'h00_000f};
   localparam logic [23:0] TS [6] = '{24'h00_0002, 24'h00_0004, 24'h00_000a,
      24'h00_0014, 24'h00_0020, 24'h00_0000};
   localparam int EXP_PD [4] = '{16, 8, 4, 1};
   logic clk, nrst, chip_enable, soft_power_down, main_cmp, aux_cmp;
   wire ser_clk, ser_data, ser_latch;
   logic main_held, aux_held, main_hiz, aux_hiz, pd_stb, ld_stb, aux_stb, qrate, acc, pwr;
   pcp_slip_t slip;
   logic [13:0] toc;
   logic [3:0] cpf;
   int miscompares, checked, n_pd, n_ld, n_aux, i, n;
   logic [23:0] w;
   bit got;
   wire [23:0] stat = {18'h0, qrate, main_held, aux_held, main_hiz, aux_hiz, pwr};
   wire [23:0] fast = {slip, cpf, toc, 4'h0};

   pcp_control #(.PWRUP_RST_CYC(PWR)) pcp_control_inst (.clk(clk), .nrst(nrst),
      .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch),
      .chip_enable(chip_enable), .soft_power_down(soft_power_down),
      .main_compare_strobe(main_cmp), .aux_compare_strobe(aux_cmp),
      .main_counters_held(main_held), .aux_counters_held(aux_held),
      .main_pump_hiz(main_hiz), .aux_pump_hiz(aux_hiz), .main_pd_sample_strobe(pd_stb),
      .main_lock_detect_strobe(ld_stb), .aux_lock_detect_strobe(aux_stb),
      .cycle_slip_reduction(slip), .fastlock_timeout_count(toc), .fastlock_pump_current(cpf),
      .lock_detect_quarter_rate(qrate), .word_accepted(acc), .power_up_reset_active(pwr));
   pcp_host_model pcp_host_model_inst (.ser_clk(ser_clk), .ser_data(ser_data),
      .ser_latch(ser_latch));

   always #20 clk = ~clk;
   // Strobes counted mid-cycle so the registered outputs have settled
   always @(negedge clk) begin
      n_pd += int'(pd_stb === 1'b1);
      n_ld += int'(ld_stb === 1'b1);
      n_aux += int'(aux_stb === 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] got_v, input logic [23:0] exp_v);
      checked++;
      if (got_v !== exp_v) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask : chk
   task automatic results;
      if (miscompares == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   task automatic wr(input logic [23:0] word, input int nb, output bit ok);
      pcp_host_model_inst.send(word, nb);
      ok = 1'b0;
      repeat (12) begin
         @(posedge clk);
         #1;
         if (acc === 1'b1) ok = 1'b1;
      end
   endtask : wr
   task automatic pulses(input int np);
      n_pd = 0;
      n_ld = 0;
      n_aux = 0;
      repeat (np) begin
         @(posedge clk);
         main_cmp <= 1'b1;
         aux_cmp <= 1'b1;
         @(posedge clk);
         main_cmp <= 1'b0;
         aux_cmp <= 1'b0;
      end
      repeat (3) @(posedge clk);
   endtask : pulses
   task automatic wait_power(output int nc);
      nc = 0;
      while (pwr !== 1'b0 && nc < 100) begin
         @(posedge clk);
         #1;
         nc++;
      end
      if (nc >= 100) begin
         miscompares++;
         results();
      end
      repeat (2) @(posedge clk);
   endtask : wait_power

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      chip_enable = 1'b0;
      soft_power_down = 1'b0;
      main_cmp = 1'b0;
      aux_cmp = 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(stat, 24'h00_001f);
      chk(fast, 24'h00_0000);
      chip_enable <= 1'b1;
      wait_power(n);
      chk({23'h0, n >= PWR}, 24'h00_0001);
      for (i = 0; i < 6; i++) begin
         wr(TW[i], 24, got);
         chk({23'h0, got}, 24'h00_0001);
         chk(stat, TS[i]);
      end
      wr(24'h00_010e, 24, got);
      chk({23'h0, got}, 24'h00_0000);
      wr(24'h00_010f, 20, got);
      chk({23'h0, got}, 24'h00_0000);
      chk(stat, 24'h00_0000);
      wr(24'h00_010f, 24, got);
      for (i = 0; i < 4; i++) begin
         w = {i[1:0], 4'(i + 7), 14'h2a5c, 4'hd};
         wr(w, 24, got);
         chk(fast, w & 24'hff_fff0);
         pulses(16);
         chk(24'(n_pd), 24'(EXP_PD[i]));
         chk(24'(n_ld), 24'h00_0004);
         chk(24'(n_aux), 24'h00_0010);
      end
      @(posedge clk);
      soft_power_down <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk(stat, 24'h00_003f);
      @(posedge clk);
      soft_power_down <= 1'b0;
      wait_power(n);
      #1;
      chk(stat, 24'h00_0020);
      results();
   end
endmodule : testbench

bind pcp_control pcp_assertions #(.PWRUP_RST_CYC(PWRUP_RST_CYC), .DIV_W(DIV_W))
   pcp_assertions_inst (.clk(clk), .nrst(nrst), .main_compare_strobe(main_compare_strobe),
   .aux_compare_strobe(aux_compare_strobe), .main_counters_held(main_counters_held),
   .aux_counters_held(aux_counters_held), .main_pump_hiz(main_pump_hiz),
   .aux_pump_hiz(aux_pump_hiz), .main_pd_sample_strobe(main_pd_sample_strobe),
   .main_lock_detect_strobe(main_lock_detect_strobe),
   .aux_lock_detect_strobe(aux_lock_detect_strobe),
   .cycle_slip_reduction(cycle_slip_reduction),
   .lock_detect_quarter_rate(lock_detect_quarter_rate), .word_accepted(word_accepted),
   .power_up_reset_active(power_up_reset_active));
